// ==== fgwt_pkg.sv ====
package fgwt_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_TRAP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_LAST_TRAP = 8'h0C;

  // ---------------------------------------------------------------------------
  // trap control slice layout
  // ---------------------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // bits 29,27,24,17,16,13,12,11 always present
  localparam logic [31:0] CTRL_BASE_MASK = 32'h2903_3800;
  // bits 23,22,20,19 only with the limited ordering feature
  localparam logic [31:0] CTRL_LOR_MASK = 32'h00D8_0000;

  localparam int BIT_SYS_CONTROL = 29;
  localparam int BIT_PHYS_ADDR_RESULT = 27;
  localparam int BIT_MEM_ATTR_INDIRECTION = 24;
  localparam int BIT_LO_REGION_START = 23;
  localparam int BIT_LO_REGION_NUMBER = 22;
  localparam int BIT_LO_REGION_END = 20;
  localparam int BIT_LO_REGION_CONTROL = 19;
  localparam int BIT_FAULT_ADDRESS = 17;
  localparam int BIT_EXCEPTION_SYNDROME = 16;
  localparam int BIT_CACHE_SIZE_SELECT = 13;
  localparam int BIT_FEATURE_ACCESS_CTRL = 12;
  localparam int BIT_CONTEXT_ID = 11;

  // ---------------------------------------------------------------------------
  // target system register identifiers of a write instruction
  // ---------------------------------------------------------------------------
  localparam int REG_ID_W = 4;
  localparam int NUM_REG_IDS = 13;
  localparam logic [3:0] REG_SYS_CONTROL = 4'h0;
  localparam logic [3:0] REG_SYS_CONTROL_EXT = 4'h1;
  localparam logic [3:0] REG_PHYS_ADDR_RESULT = 4'h2;
  localparam logic [3:0] REG_MEM_ATTR_INDIRECTION = 4'h3;
  localparam logic [3:0] REG_LO_REGION_START = 4'h4;
  localparam logic [3:0] REG_LO_REGION_NUMBER = 4'h5;
  localparam logic [3:0] REG_LO_REGION_END = 4'h6;
  localparam logic [3:0] REG_LO_REGION_CONTROL = 4'h7;
  localparam logic [3:0] REG_FAULT_ADDRESS = 4'h8;
  localparam logic [3:0] REG_EXCEPTION_SYNDROME = 4'h9;
  localparam logic [3:0] REG_CACHE_SIZE_SELECT = 4'hA;
  localparam logic [3:0] REG_FEATURE_ACCESS_CTRL = 4'hB;
  localparam logic [3:0] REG_CONTEXT_ID = 4'hC;

  // control bit that governs each register identifier
  localparam logic [4:0] BIT_OF_REG [0:12] = '{
    5'h1D, 5'h1D, 5'h1B, 5'h18, 5'h17, 5'h16, 5'h14, 5'h13, 5'h11, 5'h10, 5'h0D, 5'h0C, 5'h0B
  };

  // ---------------------------------------------------------------------------
  // exception levels, syndrome, status bits
  // ---------------------------------------------------------------------------
  localparam logic [1:0] LEVEL_KERNEL = 2'h1;
  localparam int EC_W = 6;
  localparam logic [5:0] EC_SYSREG_TRAP = 6'h18;
  localparam logic [5:0] EC_NONE = 6'h00;
  localparam int STAT_W = 2;
  localparam int STAT_TRAP = 0;
  localparam int STAT_PREEMPT = 1;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam int LAST_VALID_BIT = 8;

endpackage

// ==== trap_select.sv ====
`timescale 1ns/1ps
module trap_select #(
  parameter bit SYS_CONTROL_EXT_FEATURE = 1'b1
) (
  input wire logic [3:0] reg_id_i,
  output logic [31:0] sel_o
);

  // ---------------------------------------------------------------------------
  // register identifier to control bit one-hot
  // ---------------------------------------------------------------------------
  logic id_known;
  logic [4:0] bit_idx;

  // second control register only exists with its feature
  assign id_known = (32'(reg_id_i) < fgwt_pkg::NUM_REG_IDS) &&
                    ((reg_id_i != fgwt_pkg::REG_SYS_CONTROL_EXT) || SYS_CONTROL_EXT_FEATURE);
  assign bit_idx = id_known ? fgwt_pkg::BIT_OF_REG[reg_id_i] : 5'h00;

  // one comparator per control bit
  genvar b;
  generate
    for (b = 0; b < fgwt_pkg::DATA_W; b++) begin : g_sel
      assign sel_o[b] = id_known && (bit_idx == 5'(b));
    end
  endgenerate

endmodule

// ==== fine_grained_write_trap_ctrl.sv ====
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
// Operation
// - trap only when hypervisor level enabled
// - also needs no monitor or monitor enable
// - trap goes to hypervisor, class 0x18
// - higher priority exception wins over trap
// - all fields reset to zero
// - zero field leaves writes untrapped
// - bit 29 covers both system control registers
// - bit 27 covers physical address result
// - bit 24 covers memory attribute indirection
// - bits 23,22 region start/number, feature only
// - bits 20,19 region end/control, feature only
// - bit 17 covers fault address
// - bit 16 covers exception syndrome
// - bit 13 covers cache size selection
// - bit 12 covers feature access control
// - bit 11 covers context identifier
module fine_grained_write_trap_ctrl #(
  parameter bit LIMITED_ORDERING_FEATURE = 1'b1,
  parameter bit SYS_CONTROL_EXT_FEATURE = 1'b1
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // qualifiers from the surrounding processor state
  input wire logic el2_enabled_i,
  input wire logic el3_implemented_i,
  input wire logic monitor_fine_trap_enable_i,
  // system register write instruction to check
  input wire logic sysreg_write_instr_i,
  input wire logic [1:0] sysreg_write_level_i,
  input wire logic sysreg_write_64bit_i,
  input wire logic [3:0] sysreg_write_reg_id_i,
  input wire logic sysreg_write_higher_exc_i,
  // verdict
  output logic trap_o,
  output logic [5:0] trap_ec_o,
  output logic write_ok_o,
  output logic irq_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [1:0] status_r;
  logic [1:0] status_nxt;
  logic [1:0] mask_r;
  logic [1:0] mask_nxt;
  logic [3:0] last_id_r;
  logic [3:0] last_id_nxt;
  logic last_valid_r;
  logic last_valid_nxt;
  logic trap_r;
  logic [5:0] ec_r;
  logic write_ok_r;
  logic irq_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  logic sel_ctrl;
  logic sel_status;
  logic sel_mask;
  logic sel_last;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_status;

  assign sel_ctrl = (reg_addr_i == fgwt_pkg::ADDR_TRAP_CTRL);
  assign sel_status = (reg_addr_i == fgwt_pkg::ADDR_IRQ_STATUS);
  assign sel_mask = (reg_addr_i == fgwt_pkg::ADDR_IRQ_MASK);
  assign sel_last = (reg_addr_i == fgwt_pkg::ADDR_LAST_TRAP);
  assign wr_ctrl = reg_wr_i && sel_ctrl;
  assign wr_mask = reg_wr_i && sel_mask;
  assign rd_status = reg_rd_i && sel_status;

  // ---------------------------------------------------------------------------
  // implemented field mask
  // ---------------------------------------------------------------------------
  logic [31:0] impl_mask;

  // region bits exist only with the feature, reserved bits never
  assign impl_mask = fgwt_pkg::CTRL_BASE_MASK |
                     (LIMITED_ORDERING_FEATURE ? fgwt_pkg::CTRL_LOR_MASK : 32'h0000_0000);

  // reserved and absent fields drop written values
  assign ctrl_nxt = wr_ctrl ? (reg_wdata_i & impl_mask) : ctrl_r;

  // ---------------------------------------------------------------------------
  // target register to control bit
  // ---------------------------------------------------------------------------
  logic [31:0] reg_sel;

  // second control register shares the first one's bit
  trap_select #(
    .SYS_CONTROL_EXT_FEATURE(SYS_CONTROL_EXT_FEATURE)
  ) u_trap_select (
    .reg_id_i(sysreg_write_reg_id_i),
    .sel_o(reg_sel)
  );

  // ---------------------------------------------------------------------------
  // trap decision
  // ---------------------------------------------------------------------------
  logic field_set;
  logic level_ok;
  logic el2_ok;
  logic monitor_ok;
  logic would_trap;
  logic trap_hit;
  logic preempt_hit;

  // selected field must be one; a cleared field never traps
  assign field_set = |(reg_sel & ctrl_r);
  assign level_ok = (sysreg_write_level_i == fgwt_pkg::LEVEL_KERNEL) && sysreg_write_64bit_i;
  assign el2_ok = el2_enabled_i;
  assign monitor_ok = !el3_implemented_i || monitor_fine_trap_enable_i;
  assign would_trap = sysreg_write_instr_i && level_ok && field_set && el2_ok && monitor_ok;
  // a higher priority exception takes the write instead
  assign trap_hit = would_trap && !sysreg_write_higher_exc_i;
  assign preempt_hit = would_trap && sysreg_write_higher_exc_i;

  // ---------------------------------------------------------------------------
  // status, mask and last trap bookkeeping
  // ---------------------------------------------------------------------------
  logic [1:0] events;

  assign events = {preempt_hit, trap_hit};
  // read clears, a new event in the same cycle stays set
  assign status_nxt = (rd_status ? fgwt_pkg::STAT_RESET : status_r) | events;
  assign mask_nxt = wr_mask ? reg_wdata_i[1:0] : mask_r;
  assign last_id_nxt = trap_hit ? sysreg_write_reg_id_i : last_id_r;
  assign last_valid_nxt = last_valid_r || trap_hit;

  // ---------------------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------------------
  logic [31:0] last_word;

  assign last_word = {23'h00_0000, last_valid_r, 4'h0, last_id_r};
  // unmapped addresses read zero
  assign rdata_nxt = !reg_rd_i ? 32'h0000_0000 :
                     sel_ctrl ? ctrl_r :
                     sel_status ? {30'h0000_0000, status_r} :
                     sel_mask ? {30'h0000_0000, mask_r} :
                     sel_last ? last_word : 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------

  // trap control slice, zero on warm reset
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= fgwt_pkg::CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // interrupt status and mask
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_r <= fgwt_pkg::STAT_RESET;
      mask_r <= fgwt_pkg::MASK_RESET;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= |(status_nxt & mask_nxt);
    end
  end

  // last trapped register
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_id_r <= 4'h0;
      last_valid_r <= 1'b0;
    end else begin
      last_id_r <= last_id_nxt;
      last_valid_r <= last_valid_nxt;
    end
  end

  // verdict outputs, one cycle after the instruction
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trap_r <= 1'b0;
      ec_r <= fgwt_pkg::EC_NONE;
      write_ok_r <= 1'b0;
    end else begin
      trap_r <= trap_hit;
      ec_r <= trap_hit ? fgwt_pkg::EC_SYSREG_TRAP : fgwt_pkg::EC_NONE;
      write_ok_r <= sysreg_write_instr_i && !would_trap && !sysreg_write_higher_exc_i;
    end
  end

  // read data stands for one cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign trap_o = trap_r;
  assign trap_ec_o = ec_r;
  assign write_ok_o = write_ok_r;
  assign irq_o = irq_r;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  logic ctrl_written_r;

  // helper: any write to the control slice since reset
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_written_r <= 1'b0;
    end else begin
      ctrl_written_r <= ctrl_written_r || wr_ctrl;
    end
  end

  chk_trap_el2_gate: assert property (
    trap_o |-> $past(el2_enabled_i) && $past(sysreg_write_instr_i)
  ) else $error("trap without hypervisor level enabled");

  chk_trap_monitor_gate: assert property (
    (sysreg_write_instr_i && el3_implemented_i && !monitor_fine_trap_enable_i) |=> !trap_o
  ) else $error("trap while monitor enable clear");

  chk_trap_class_code: assert property (
    trap_o |-> (trap_ec_o == fgwt_pkg::EC_SYSREG_TRAP) && !write_ok_o
  ) else $error("trap class code wrong");

  chk_higher_exc_wins: assert property (
    (sysreg_write_instr_i && sysreg_write_higher_exc_i) |=> !trap_o && !write_ok_o
  ) else $error("trap taken over higher priority exception");

  chk_reset_fields_zero: assert property (
    !ctrl_written_r |-> (ctrl_r == fgwt_pkg::CTRL_RESET)
  ) else $error("control field nonzero before any write");

  chk_clear_untrapped: assert property (
    (sysreg_write_instr_i && !sysreg_write_higher_exc_i && !(|(reg_sel & ctrl_r))) |=> !trap_o && write_ok_o
  ) else $error("cleared field trapped or blocked a write");

  chk_sys_control_trap: assert property (
    (sysreg_write_instr_i && level_ok && el2_ok && monitor_ok && !sysreg_write_higher_exc_i &&
     (sysreg_write_reg_id_i == fgwt_pkg::REG_SYS_CONTROL) && ctrl_r[fgwt_pkg::BIT_SYS_CONTROL])
    |=> trap_o && (trap_ec_o == fgwt_pkg::EC_SYSREG_TRAP)
  ) else $error("system control write not trapped");

  chk_phys_addr_trap: assert property (
    (sysreg_write_instr_i && level_ok && el2_ok && monitor_ok && !sysreg_write_higher_exc_i &&
     (sysreg_write_reg_id_i == fgwt_pkg::REG_PHYS_ADDR_RESULT) && ctrl_r[fgwt_pkg::BIT_PHYS_ADDR_RESULT])
    |=> trap_o
  ) else $error("physical address result write not trapped");

  chk_field_selects: assert property (
    trap_o |-> $past(field_set) && $past(level_ok)
  ) else $error("trap without its control field set");

  chk_region_absent: assert property (
    !LIMITED_ORDERING_FEATURE |-> ((ctrl_r & fgwt_pkg::CTRL_LOR_MASK) == 32'h0000_0000)
  ) else $error("region bits set without feature");

  chk_reserved_zero: assert property (
    wr_ctrl |=> ((ctrl_r & ~(fgwt_pkg::CTRL_BASE_MASK | fgwt_pkg::CTRL_LOR_MASK)) == 32'h0000_0000)
  ) else $error("reserved control bit set");

  chk_ctrl_read_back: assert property (
    (reg_rd_i && sel_ctrl) |=> (reg_rdata_o == $past(ctrl_r))
  ) else $error("control read data wrong");

  chk_irq_level: assert property (
    irq_o == (|(status_r & mask_r))
  ) else $error("interrupt level does not follow status and mask");

  chk_status_set_wins: assert property (
    (rd_status && trap_hit) |=> status_r[fgwt_pkg::STAT_TRAP]
  ) else $error("trap event lost against status read");

  // helper: a write meeting every qualifier, not preempted
  logic write_qualified;
  assign write_qualified = sysreg_write_instr_i && sysreg_write_64bit_i && !sysreg_write_higher_exc_i &&
                           (sysreg_write_level_i == fgwt_pkg::LEVEL_KERNEL) && el2_enabled_i &&
                           (!el3_implemented_i || monitor_fine_trap_enable_i);

  chk_sys_control_ext: assert property (
    (write_qualified && (sysreg_write_reg_id_i == fgwt_pkg::REG_SYS_CONTROL_EXT) &&
     ctrl_r[fgwt_pkg::BIT_SYS_CONTROL]) |=> (trap_o == SYS_CONTROL_EXT_FEATURE)
  ) else $error("second control write trap wrong");

  chk_mem_attr_trap: assert property (
    (write_qualified && (sysreg_write_reg_id_i == fgwt_pkg::REG_MEM_ATTR_INDIRECTION) &&
     ctrl_r[fgwt_pkg::BIT_MEM_ATTR_INDIRECTION]) |=> trap_o
  ) else $error("memory attribute write not trapped");

  chk_region_start_number: assert property (
    (write_qualified &&
     (((sysreg_write_reg_id_i == fgwt_pkg::REG_LO_REGION_START) && ctrl_r[fgwt_pkg::BIT_LO_REGION_START]) ||
      ((sysreg_write_reg_id_i == fgwt_pkg::REG_LO_REGION_NUMBER) && ctrl_r[fgwt_pkg::BIT_LO_REGION_NUMBER])))
    |=> trap_o
  ) else $error("region start or number write not trapped");

  chk_region_end_control: assert property (
    (write_qualified &&
     (((sysreg_write_reg_id_i == fgwt_pkg::REG_LO_REGION_END) && ctrl_r[fgwt_pkg::BIT_LO_REGION_END]) ||
      ((sysreg_write_reg_id_i == fgwt_pkg::REG_LO_REGION_CONTROL) && ctrl_r[fgwt_pkg::BIT_LO_REGION_CONTROL])))
    |=> trap_o
  ) else $error("region end or control write not trapped");

  chk_fault_addr_trap: assert property (
    (write_qualified && (sysreg_write_reg_id_i == fgwt_pkg::REG_FAULT_ADDRESS) &&
     ctrl_r[fgwt_pkg::BIT_FAULT_ADDRESS]) |=> trap_o
  ) else $error("fault address write not trapped");

  chk_syndrome_trap: assert property (
    (write_qualified && (sysreg_write_reg_id_i == fgwt_pkg::REG_EXCEPTION_SYNDROME) &&
     ctrl_r[fgwt_pkg::BIT_EXCEPTION_SYNDROME]) |=> trap_o
  ) else $error("syndrome write not trapped");

  chk_cache_select_trap: assert property (
    (write_qualified && (sysreg_write_reg_id_i == fgwt_pkg::REG_CACHE_SIZE_SELECT) &&
     ctrl_r[fgwt_pkg::BIT_CACHE_SIZE_SELECT]) |=> trap_o
  ) else $error("cache size select write not trapped");

  chk_feature_access_trap: assert property (
    (write_qualified && (sysreg_write_reg_id_i == fgwt_pkg::REG_FEATURE_ACCESS_CTRL) &&
     ctrl_r[fgwt_pkg::BIT_FEATURE_ACCESS_CTRL]) |=> trap_o
  ) else $error("feature access write not trapped");

  chk_context_id_trap: assert property (
    (write_qualified && (sysreg_write_reg_id_i == fgwt_pkg::REG_CONTEXT_ID) &&
     ctrl_r[fgwt_pkg::BIT_CONTEXT_ID]) |=> trap_o
  ) else $error("context id write not trapped");

  chk_read_data_stands: assert property (
    !reg_rd_i |=> (reg_rdata_o == 32'h0000_0000)
  ) else $error("read data outlived its cycle");

endmodule

// ==== test_fine_grained_write_trap_ctrl.sv ====
`timescale 1ns/1ps
module test_fine_grained_write_trap_ctrl;
  // ---------------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------------
  // one table row: control value, {el2, el3, monitor enable, 64-bit}, level, id, higher exc, trap expected
  typedef struct packed {
    logic [31:0] ctrl;
    logic [3:0] q;
    logic [1:0] lvl;
    logic [3:0] id;
    logic hx;
    logic et;
  } row_s;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic el2_enabled_i = 1'b0;
  logic el3_implemented_i = 1'b0;
  logic monitor_fine_trap_enable_i = 1'b0;
  logic sysreg_write_instr_i = 1'b0;
  logic [1:0] sysreg_write_level_i = 2'h0;
  logic sysreg_write_64bit_i = 1'b0;
  logic [3:0] sysreg_write_reg_id_i = 4'h0;
  logic sysreg_write_higher_exc_i = 1'b0;
  logic trap_o;
  logic [5:0] trap_ec_o;
  logic write_ok_o;
  logic irq_o;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;
  row_s rows [0:21];
  logic [31:0] bare_rdata;
  logic bare_trap;
  logic bare_write_ok;

  fine_grained_write_trap_ctrl fine_grained_write_trap_ctrl_i (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .el2_enabled_i(el2_enabled_i),
    .el3_implemented_i(el3_implemented_i),
    .monitor_fine_trap_enable_i(monitor_fine_trap_enable_i),
    .sysreg_write_instr_i(sysreg_write_instr_i),
    .sysreg_write_level_i(sysreg_write_level_i),
    .sysreg_write_64bit_i(sysreg_write_64bit_i),
    .sysreg_write_reg_id_i(sysreg_write_reg_id_i),
    .sysreg_write_higher_exc_i(sysreg_write_higher_exc_i),
    .trap_o(trap_o),
    .trap_ec_o(trap_ec_o),
    .write_ok_o(write_ok_o),
    .irq_o(irq_o)
  );

  // same block without either optional feature
  fine_grained_write_trap_ctrl #(
    .LIMITED_ORDERING_FEATURE(1'b0),
    .SYS_CONTROL_EXT_FEATURE(1'b0)
  ) fine_grained_write_trap_ctrl_bare_i (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(bare_rdata),
    .el2_enabled_i(el2_enabled_i),
    .el3_implemented_i(el3_implemented_i),
    .monitor_fine_trap_enable_i(monitor_fine_trap_enable_i),
    .sysreg_write_instr_i(sysreg_write_instr_i),
    .sysreg_write_level_i(sysreg_write_level_i),
    .sysreg_write_64bit_i(sysreg_write_64bit_i),
    .sysreg_write_reg_id_i(sysreg_write_reg_id_i),
    .sysreg_write_higher_exc_i(sysreg_write_higher_exc_i),
    .trap_o(bare_trap),
    .trap_ec_o(),
    .write_ok_o(bare_write_ok),
    .irq_o()
  );

  // 250 MHz clock and hang guard
  always #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------------------
  // bus, instruction and compare tasks
  // ---------------------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic sysreg_write(input logic [3:0] q, input logic [1:0] lvl, input logic [3:0] id, input logic hx);
    @(posedge core_clk_i);
    {el2_enabled_i, el3_implemented_i, monitor_fine_trap_enable_i, sysreg_write_64bit_i} <= q;
    sysreg_write_level_i <= lvl;
    sysreg_write_reg_id_i <= id;
    sysreg_write_higher_exc_i <= hx;
    sysreg_write_instr_i <= 1'b1;
    @(posedge core_clk_i);
    sysreg_write_instr_i <= 1'b0;
    #1;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected data at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // verdict packs trap, class and write-proceeds into one byte
  task automatic chk_verdict(input logic et, input logic hx);
    logic [7:0] exp;
    exp = {et, et ? fgwt_pkg::EC_SYSREG_TRAP : fgwt_pkg::EC_NONE, !et && !hx};
    comparisons++;
    if ({trap_o, trap_ec_o, write_ok_o} !== exp) begin
      error_cnt++;
      $display("unexpected verdict at %0t: got %h, expected %h", $time, {trap_o, trap_ec_o, write_ok_o}, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rows = '{
      '{32'h2000_0000, 4'b1001, 2'h1, 4'h0, 1'b0, 1'b1},
      '{32'h2000_0000, 4'b1001, 2'h1, 4'h1, 1'b0, 1'b1},
      '{32'h0800_0000, 4'b1001, 2'h1, 4'h2, 1'b0, 1'b1},
      '{32'h0100_0000, 4'b1001, 2'h1, 4'h3, 1'b0, 1'b1},
      '{32'h0080_0000, 4'b1001, 2'h1, 4'h4, 1'b0, 1'b1},
      '{32'h0040_0000, 4'b1001, 2'h1, 4'h5, 1'b0, 1'b1},
      '{32'h0010_0000, 4'b1001, 2'h1, 4'h6, 1'b0, 1'b1},
      '{32'h0008_0000, 4'b1001, 2'h1, 4'h7, 1'b0, 1'b1},
      '{32'h0002_0000, 4'b1001, 2'h1, 4'h8, 1'b0, 1'b1},
      '{32'h0001_0000, 4'b1001, 2'h1, 4'h9, 1'b0, 1'b1},
      '{32'h0000_2000, 4'b1001, 2'h1, 4'hA, 1'b0, 1'b1},
      '{32'h0000_1000, 4'b1001, 2'h1, 4'hB, 1'b0, 1'b1},
      '{32'h0000_0800, 4'b1001, 2'h1, 4'hC, 1'b0, 1'b1},
      '{32'h09DB_3800, 4'b1001, 2'h1, 4'h0, 1'b0, 1'b0},
      '{32'h0800_0000, 4'b1001, 2'h1, 4'hC, 1'b0, 1'b0},
      '{32'h29DB_3800, 4'b1001, 2'h1, 4'hD, 1'b0, 1'b0},
      '{32'h2000_0000, 4'b0001, 2'h1, 4'h0, 1'b0, 1'b0},
      '{32'h2000_0000, 4'b1101, 2'h1, 4'h0, 1'b0, 1'b0},
      '{32'h2000_0000, 4'b1111, 2'h1, 4'h0, 1'b0, 1'b1},
      '{32'h2000_0000, 4'b1001, 2'h1, 4'h0, 1'b1, 1'b0},
      '{32'h2000_0000, 4'b1001, 2'h0, 4'h0, 1'b0, 1'b0},
      '{32'h2000_0000, 4'b1000, 2'h1, 4'h0, 1'b0, 1'b0}
    };
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    reg_read(fgwt_pkg::ADDR_TRAP_CTRL, rd);
    chk_data(rd, fgwt_pkg::CTRL_RESET);
    // trap table, interrupt masked throughout
    foreach (rows[i]) begin
      reg_write(fgwt_pkg::ADDR_TRAP_CTRL, rows[i].ctrl);
      sysreg_write(rows[i].q, rows[i].lvl, rows[i].id, rows[i].hx);
      chk_verdict(rows[i].et, rows[i].hx);
    end
    chk_data({31'h0000_0000, irq_o}, 32'h0000_0000);
    // status holds a trap and a preempted trap; read clears
    reg_read(fgwt_pkg::ADDR_IRQ_STATUS, rd);
    chk_data(rd, 32'h0000_0003);
    reg_read(fgwt_pkg::ADDR_IRQ_STATUS, rd);
    chk_data(rd, 32'h0000_0000);
    // reserved and absent positions dropped, unmapped place reads zero
    reg_write(fgwt_pkg::ADDR_TRAP_CTRL, 32'hFFFF_FFFF);
    reg_read(fgwt_pkg::ADDR_TRAP_CTRL, rd);
    chk_data(rd, fgwt_pkg::CTRL_BASE_MASK | fgwt_pkg::CTRL_LOR_MASK);
    chk_data(bare_rdata, fgwt_pkg::CTRL_BASE_MASK);
    // region and second control ids trap only where their feature exists
    sysreg_write(4'b1001, 2'h1, 4'h4, 1'b0);
    chk_verdict(1'b1, 1'b0);
    chk_data({30'h0000_0000, bare_trap, bare_write_ok}, 32'h0000_0001);
    sysreg_write(4'b1001, 2'h1, 4'h1, 1'b0);
    chk_verdict(1'b1, 1'b0);
    chk_data({30'h0000_0000, bare_trap, bare_write_ok}, 32'h0000_0001);
    reg_write(8'h10, 32'hFFFF_FFFF);
    reg_read(8'h10, rd);
    chk_data(rd, 32'h0000_0000);
    reg_write(fgwt_pkg::ADDR_IRQ_MASK, 32'hFFFF_FFFF);
    reg_read(fgwt_pkg::ADDR_IRQ_MASK, rd);
    chk_data(rd, 32'h0000_0003);
    // unmasked trap raises the interrupt until status is read
    reg_write(fgwt_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
    sysreg_write(4'b1001, 2'h1, 4'hC, 1'b0);
    chk_verdict(1'b1, 1'b0);
    @(posedge core_clk_i);
    #1;
    chk_data({31'h0000_0000, irq_o}, 32'h0000_0001);
    reg_read(fgwt_pkg::ADDR_LAST_TRAP, rd);
    chk_data(rd, 32'h0000_010C);
    reg_read(fgwt_pkg::ADDR_IRQ_STATUS, rd);
    chk_data(rd, 32'h0000_0001);
    @(posedge core_clk_i);
    #1;
    chk_data({31'h0000_0000, irq_o}, 32'h0000_0000);
    // preempted trap shows only through its own mask bit
    reg_write(fgwt_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
    sysreg_write(4'b1001, 2'h1, 4'hB, 1'b1);
    chk_verdict(1'b0, 1'b1);
    @(posedge core_clk_i);
    #1;
    chk_data({31'h0000_0000, irq_o}, 32'h0000_0001);
    // two instructions one idle cycle apart, then a warm reset in mid-run
    sysreg_write(4'b1001, 2'h1, 4'hA, 1'b0);
    chk_verdict(1'b1, 1'b0);
    sysreg_write(4'b1001, 2'h1, 4'h3, 1'b0);
    chk_verdict(1'b1, 1'b0);
    // status read and a trap in one cycle: the new event survives the clear
    @(posedge core_clk_i);
    reg_addr_i <= fgwt_pkg::ADDR_IRQ_STATUS;
    reg_rd_i <= 1'b1;
    sysreg_write_instr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    sysreg_write_instr_i <= 1'b0;
    #1;
    chk_verdict(1'b1, 1'b0);
    chk_data(reg_rdata_o, 32'h0000_0003);
    reg_read(fgwt_pkg::ADDR_IRQ_STATUS, rd);
    chk_data(rd, 32'h0000_0001);
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk_data({24'h00_0000, trap_o, trap_ec_o, irq_o}, 32'h0000_0000);
    @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    reg_read(fgwt_pkg::ADDR_TRAP_CTRL, rd);
    chk_data(rd, fgwt_pkg::CTRL_RESET);
    sysreg_write(4'b1001, 2'h1, 4'h0, 1'b0);
    chk_verdict(1'b0, 1'b0);
    end_of_test();
  end
endmodule
